// file: design/service_exit_factory_restore.sv
`timescale 1ns/1ns
`include "svc_consts.svh"
// Notes on behaviour
// [RQ1] exit_target n: confirm if dirty, then Normal
// [RQ2] Confirming exits wait three seconds before executing
// [RQ3] exit_target i: confirm if dirty, then Init
// [RQ4] Entering Init reloads unsaved settings from flash
// [RQ5] exit_target N: Normal at once, no confirm
// [RQ6] exit_target I: Init at once, no confirm
// [RQ7] Answer N keeps service mode, shows prompt
// [RQ8] Other answers report invalid parameter, no exit
// [RQ9] Report unknown command, parameter count, invalid value
// [RQ10] Plain restore loads factory settings, not saved
// [RQ11] Restore with s also writes flash
// [RQ12] Factory restore needs a Y confirmation first
// [RQ13] Changed transmission settings need second confirmation
// [RQ14] Count saves, warn above 1000, always save
// [RQ15] Failed flash write reports save error
// [RQ16] Extra characters after plain restore: count error
// [RQ17] Saved restore reports saved plus save count
// [RQ18] Unsaved restore reports applied, advises save command
// [RQ19] Staying in service mode ends with prompt
module service_exit_factory_restore #(
   parameter int unsigned HOLD_CYCLES = `HOLD_TIME_MS * `CLK_FREQ_KHZ,
   parameter int unsigned HOLD_W      = 28
) (
   input  wire logic                    clk,           // 50 MHz system clock
   input  wire logic                    rstn,          // Async reset, active low
   input  wire logic                    rx_valid,      // Received character strobe
   input  wire logic [7:0]              rx_data,       // Received character
   input  wire logic                    enter_service, // Pulse: unit enters service mode
   input  wire logic                    cfg_dirty,     // Live settings differ from flash
   input  wire logic                    tx_change,     // Factory set alters link settings
   input  wire logic                    flash_done,    // Pulse: flash write finished
   input  wire logic                    flash_ok,      // Flash write result, with done
   output logic                         msg_valid,     // Pulse: message to send
   output svc_pkg::msg_t                msg_code,      // Message identifier
   output logic                         in_service,    // Service mode active
   output logic                         goto_normal,   // Pulse: switch to normal mode
   output logic                         goto_init,     // Pulse: switch to init mode
   output logic                         reload_flash,  // Pulse: live settings from flash
   output logic                         load_factory,  // Pulse: live settings from factory
   output logic                         flash_save,    // Pulse: write live settings to flash
   output logic [`SAVE_CNT_W-1:0]       save_count     // Number of flash saves
);

   svc_pkg::state_t         state_reg;
   svc_pkg::msg_t           err_reg;
   logic [7:0]              target_reg;
   logic                    save_reg;
   logic [HOLD_W-1:0]       hold_cnt_reg;

   function automatic logic is_init(input logic [7:0] ch);
      is_init = (ch == `CH_I_LC) || (ch == `CH_I_UC);
   endfunction

   function automatic logic is_exit_target(input logic [7:0] ch);
      is_exit_target = (ch == `CH_N_LC) || (ch == `CH_I_LC) ||
                       (ch == `CH_N_UC) || (ch == `CH_I_UC);
   endfunction

   function automatic logic is_line_end(input logic [7:0] ch);
      is_line_end = (ch == `CH_CR) || (ch == `CH_LF);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Hold timer: reloads outside the hold state, counts down inside it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_cnt_reg <= '0;
      end else if (state_reg != svc_pkg::ST_HOLD) begin
         hold_cnt_reg <= HOLD_W'(HOLD_CYCLES - 1);
      end else if (hold_cnt_reg != '0) begin
         hold_cnt_reg <= hold_cnt_reg - 1'b1; // RQ2
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Save counter saturates so the warning can never wrap away
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         save_count <= '0;
      end else if (state_reg == svc_pkg::ST_FLASH_WAIT && flash_done && flash_ok &&
                   save_count != '1) begin
         save_count <= save_count + 1'b1; // RQ14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command sequencer; one message per cycle, pulses default low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= svc_pkg::ST_OUT;
         err_reg      <= svc_pkg::MSG_NONE;
         target_reg   <= '0;
         save_reg     <= 1'b0;
         msg_valid    <= 1'b0;
         msg_code     <= svc_pkg::MSG_NONE;
         in_service   <= 1'b0;
         goto_normal  <= 1'b0;
         goto_init    <= 1'b0;
         reload_flash <= 1'b0;
         load_factory <= 1'b0;
         flash_save   <= 1'b0;
      end else begin
         msg_valid    <= 1'b0;
         goto_normal  <= 1'b0;
         goto_init    <= 1'b0;
         reload_flash <= 1'b0;
         load_factory <= 1'b0;
         flash_save   <= 1'b0;
         case (state_reg)
            svc_pkg::ST_OUT: begin
               if (enter_service) begin
                  in_service <= 1'b1;
                  msg_valid  <= 1'b1;
                  msg_code   <= svc_pkg::MSG_PROMPT;
                  state_reg  <= svc_pkg::ST_IDLE;
               end
            end
            svc_pkg::ST_IDLE: begin
               if (rx_valid) begin
                  if (rx_data == `CH_X_LC) begin
                     state_reg <= svc_pkg::ST_X_SP;
                  end else if (rx_data == `CH_Z_LC) begin
                     save_reg  <= 1'b0;
                     state_reg <= svc_pkg::ST_Z_CMD;
                  end else if (rx_data == `CH_CR) begin
                     state_reg <= svc_pkg::ST_PROMPT; // RQ19
                  end else if (rx_data != `CH_LF) begin
                     err_reg   <= svc_pkg::MSG_E001_UNKNOWN_CMD; // RQ9
                     state_reg <= svc_pkg::ST_SKIP;
                  end
               end
            end
            svc_pkg::ST_X_SP: begin
               if (rx_valid) begin
                  if (rx_data == `CH_SP) begin
                     state_reg <= svc_pkg::ST_X_ARG;
                  end else if (rx_data == `CH_CR) begin
                     err_reg   <= svc_pkg::MSG_E002_PARAM_COUNT; // RQ9
                     state_reg <= svc_pkg::ST_ERR;
                  end else begin
                     err_reg   <= (rx_data == `CH_COMMA) ? svc_pkg::MSG_E002_PARAM_COUNT
                                                         : svc_pkg::MSG_E001_UNKNOWN_CMD;
                     state_reg <= svc_pkg::ST_SKIP;
                  end
               end
            end
            svc_pkg::ST_X_ARG: begin
               if (rx_valid) begin
                  if (is_exit_target(rx_data)) begin
                     target_reg <= rx_data;
                     state_reg  <= svc_pkg::ST_X_CR;
                  end else if (rx_data == `CH_CR) begin
                     err_reg   <= svc_pkg::MSG_E002_PARAM_COUNT; // RQ9
                     state_reg <= svc_pkg::ST_ERR;
                  end else begin
                     err_reg   <= svc_pkg::MSG_E003_INVALID_PARAM; // RQ9
                     state_reg <= svc_pkg::ST_SKIP;
                  end
               end
            end
            svc_pkg::ST_X_CR: begin
               if (rx_valid) begin
                  if (rx_data != `CH_CR) begin
                     err_reg   <= svc_pkg::MSG_E002_PARAM_COUNT; // RQ9
                     state_reg <= svc_pkg::ST_SKIP;
                  end else begin
                     msg_valid <= 1'b1;
                     msg_code  <= is_init(target_reg) ? svc_pkg::MSG_RETURN_INIT
                                                      : svc_pkg::MSG_RETURN_NORMAL;
                     if (target_reg == `CH_N_UC || target_reg == `CH_I_UC) begin
                        state_reg <= svc_pkg::ST_EXIT_NOW; // RQ5 RQ6
                     end else if (cfg_dirty) begin
                        msg_code  <= svc_pkg::MSG_CONFIRM_EXIT; // RQ1 RQ3
                        state_reg <= svc_pkg::ST_CONF_X;
                     end else begin
                        state_reg <= svc_pkg::ST_HOLD; // RQ2
                     end
                  end
               end
            end
            svc_pkg::ST_CONF_X: begin
               // Line ends are skipped so a terminal may send Y plus CR
               if (rx_valid && !is_line_end(rx_data)) begin
                  if (rx_data == `CH_Y_UC) begin
                     msg_valid <= 1'b1;
                     msg_code  <= is_init(target_reg) ? svc_pkg::MSG_RETURN_INIT
                                                      : svc_pkg::MSG_RETURN_NORMAL;
                     state_reg <= svc_pkg::ST_HOLD; // RQ2
                  end else if (rx_data == `CH_N_UC) begin
                     state_reg <= svc_pkg::ST_PROMPT; // RQ7
                  end else begin
                     err_reg   <= svc_pkg::MSG_E003_INVALID_PARAM; // RQ8
                     state_reg <= svc_pkg::ST_ERR;
                  end
               end
            end
            svc_pkg::ST_HOLD: begin
               if (hold_cnt_reg == '0) begin
                  state_reg <= svc_pkg::ST_EXIT_NOW; // RQ2
               end
            end
            svc_pkg::ST_EXIT_NOW: begin
               in_service   <= 1'b0;
               goto_init    <= is_init(target_reg);
               reload_flash <= is_init(target_reg); // RQ4
               goto_normal  <= !is_init(target_reg);
               state_reg    <= svc_pkg::ST_OUT;
            end
            svc_pkg::ST_Z_CMD: begin
               if (rx_valid) begin
                  if (rx_data == `CH_CR) begin
                     msg_valid <= 1'b1;
                     msg_code  <= svc_pkg::MSG_RESTORE_CONFIRM; // RQ12
                     state_reg <= svc_pkg::ST_CONF_Z;
                  end else if (rx_data == `CH_SP) begin
                     state_reg <= svc_pkg::ST_Z_ARG;
                  end else begin
                     err_reg   <= svc_pkg::MSG_E002_PARAM_COUNT; // RQ16
                     state_reg <= svc_pkg::ST_SKIP;
                  end
               end
            end
            svc_pkg::ST_Z_ARG: begin
               if (rx_valid) begin
                  if (rx_data == `CH_S_LC) begin
                     save_reg  <= 1'b1; // RQ11
                     state_reg <= svc_pkg::ST_Z_CR;
                  end else if (rx_data == `CH_CR) begin
                     err_reg   <= svc_pkg::MSG_E002_PARAM_COUNT;
                     state_reg <= svc_pkg::ST_ERR;
                  end else begin
                     err_reg   <= svc_pkg::MSG_E003_INVALID_PARAM; // RQ9
                     state_reg <= svc_pkg::ST_SKIP;
                  end
               end
            end
            svc_pkg::ST_Z_CR: begin
               if (rx_valid) begin
                  if (rx_data == `CH_CR) begin
                     msg_valid <= 1'b1;
                     msg_code  <= svc_pkg::MSG_RESTORE_CONFIRM; // RQ12
                     state_reg <= svc_pkg::ST_CONF_Z;
                  end else begin
                     err_reg   <= svc_pkg::MSG_E002_PARAM_COUNT; // RQ9
                     state_reg <= svc_pkg::ST_SKIP;
                  end
               end
            end
            svc_pkg::ST_CONF_Z, svc_pkg::ST_CONF_TX: begin
               if (rx_valid && !is_line_end(rx_data)) begin
                  msg_valid <= 1'b1;
                  if (rx_data != `CH_Y_UC) begin
                     msg_code  <= svc_pkg::MSG_ABORTED;
                     err_reg   <= svc_pkg::MSG_E003_INVALID_PARAM;
                     state_reg <= (rx_data == `CH_N_UC) ? svc_pkg::ST_PROMPT
                                                        : svc_pkg::ST_ERR;
                  end else if (state_reg == svc_pkg::ST_CONF_Z && tx_change) begin
                     msg_code  <= svc_pkg::MSG_TX_CONFIRM; // RQ13
                     state_reg <= svc_pkg::ST_CONF_TX;
                  end else if (state_reg == svc_pkg::ST_CONF_TX) begin
                     msg_code  <= svc_pkg::MSG_TX_NEW_PARAMS; // RQ13
                     state_reg <= svc_pkg::ST_TX_SHOW;
                  end else begin
                     msg_code  <= svc_pkg::MSG_APPLYING; // RQ12
                     state_reg <= svc_pkg::ST_APPLY;
                  end
               end
            end
            svc_pkg::ST_TX_SHOW: begin
               msg_valid <= 1'b1;
               msg_code  <= svc_pkg::MSG_APPLYING;
               state_reg <= svc_pkg::ST_APPLY;
            end
            svc_pkg::ST_APPLY: begin
               load_factory <= 1'b1; // RQ10
               if (save_reg) begin
                  state_reg <= svc_pkg::ST_SAVE_REQ;
               end else begin
                  msg_valid <= 1'b1;
                  msg_code  <= svc_pkg::MSG_APPLIED_USE_SAVE; // RQ18
                  state_reg <= svc_pkg::ST_PROMPT;
               end
            end
            svc_pkg::ST_SAVE_REQ: begin
               flash_save <= 1'b1; // RQ11 RQ14
               state_reg  <= svc_pkg::ST_FLASH_WAIT;
            end
            svc_pkg::ST_FLASH_WAIT: begin
               if (flash_done) begin
                  msg_valid <= 1'b1;
                  if (flash_ok) begin
                     msg_code  <= svc_pkg::MSG_APPLIED_SAVED; // RQ17
                     state_reg <= svc_pkg::ST_SHOW_COUNT;
                  end else begin
                     msg_code  <= svc_pkg::MSG_E005_SAVE_FAILED; // RQ15
                     state_reg <= svc_pkg::ST_PROMPT;
                  end
               end
            end
            svc_pkg::ST_SHOW_COUNT: begin
               msg_valid <= 1'b1;
               msg_code  <= svc_pkg::MSG_SAVE_COUNT; // RQ17
               state_reg <= (save_count > `SAVE_LIMIT) ? svc_pkg::ST_WARN
                                                       : svc_pkg::ST_PROMPT;
            end
            svc_pkg::ST_WARN: begin
               msg_valid <= 1'b1;
               msg_code  <= svc_pkg::MSG_E004_MAX_SAVES; // RQ14
               state_reg <= svc_pkg::ST_PROMPT;
            end
            svc_pkg::ST_SKIP: begin
               // Rest of a bad line is swallowed; the error shows at its end
               if (rx_valid && rx_data == `CH_CR) begin
                  state_reg <= svc_pkg::ST_ERR;
               end
            end
            svc_pkg::ST_ERR: begin
               msg_valid <= 1'b1;
               msg_code  <= err_reg; // RQ9
               state_reg <= svc_pkg::ST_PROMPT;
            end
            svc_pkg::ST_PROMPT: begin
               msg_valid <= 1'b1;
               msg_code  <= svc_pkg::MSG_PROMPT; // RQ19
               state_reg <= svc_pkg::ST_IDLE;
            end
            default: begin
               state_reg <= svc_pkg::ST_OUT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_IMMEDIATE_NORMAL: assert property ( // RQ5
      (state_reg == svc_pkg::ST_X_CR && rx_valid && rx_data == `CH_CR &&
       target_reg == `CH_N_UC) |=> ##1 (goto_normal && !in_service))
      else $error("immediate normal exit not taken in two cycles");

   AST_IMMEDIATE_INIT: assert property ( // RQ6
      (state_reg == svc_pkg::ST_X_CR && rx_valid && rx_data == `CH_CR &&
       target_reg == `CH_I_UC) |=> ##1 (goto_init && reload_flash))
      else $error("immediate init exit not taken in two cycles");

   AST_HOLD_NO_EXIT: assert property ( // RQ2
      (state_reg == svc_pkg::ST_HOLD && hold_cnt_reg != '0) |=> !(goto_normal || goto_init))
      else $error("exit fired before hold time elapsed");

   AST_HOLD_END_EXIT: assert property ( // RQ2
      (state_reg == svc_pkg::ST_HOLD && hold_cnt_reg == '0) |=> ##1 (goto_normal || goto_init))
      else $error("exit missing after hold time");

   AST_INIT_RELOADS: assert property ( // RQ4
      goto_init |-> (reload_flash && !goto_normal))
      else $error("init entry without flash reload");

   AST_DIRTY_CONFIRM: assert property ( // RQ1
      (state_reg == svc_pkg::ST_X_CR && rx_valid && rx_data == `CH_CR &&
       target_reg == `CH_N_LC && cfg_dirty) |=>
      (msg_valid && msg_code == svc_pkg::MSG_CONFIRM_EXIT))
      else $error("dirty exit did not ask for confirmation");

   AST_DECLINE_STAYS: assert property ( // RQ7
      (state_reg == svc_pkg::ST_CONF_X && rx_valid && rx_data == `CH_N_UC) |=>
      ##1 (msg_valid && msg_code == svc_pkg::MSG_PROMPT && in_service))
      else $error("declined exit did not return to prompt");

   AST_BAD_ANSWER: assert property ( // RQ8
      (state_reg == svc_pkg::ST_CONF_X && rx_valid && !is_line_end(rx_data) &&
       rx_data != `CH_Y_UC && rx_data != `CH_N_UC) |=>
      ##1 (msg_code == svc_pkg::MSG_E003_INVALID_PARAM) ##1 (msg_code == svc_pkg::MSG_PROMPT))
      else $error("bad confirmation answer not reported");

   AST_Z_EXTRA_CHARS: assert property ( // RQ16
      (state_reg == svc_pkg::ST_Z_CMD && rx_valid && rx_data != `CH_CR && rx_data != `CH_SP)
      |=> (err_reg == svc_pkg::MSG_E002_PARAM_COUNT))
      else $error("extra characters after restore not flagged");

   AST_SAVE_FAIL: assert property ( // RQ15
      (state_reg == svc_pkg::ST_FLASH_WAIT && flash_done && !flash_ok) |=>
      (msg_code == svc_pkg::MSG_E005_SAVE_FAILED && $stable(save_count)))
      else $error("flash failure not reported");

   AST_SAVE_WARN: assert property ( // RQ14
      (state_reg == svc_pkg::ST_SHOW_COUNT && save_count > `SAVE_LIMIT) |=>
      ##1 (msg_valid && msg_code == svc_pkg::MSG_E004_MAX_SAVES))
      else $error("save limit warning missing");

   AST_NOSAVE_NO_FLASH: assert property ( // RQ10
      (load_factory && !save_reg) |-> ##1 (!flash_save [*2]))
      else $error("plain restore wrote flash");

   COV_IMMEDIATE_EXIT: cover property (state_reg == svc_pkg::ST_EXIT_NOW && in_service);
   COV_HOLD_EXIT: cover property (state_reg == svc_pkg::ST_HOLD ##1
                                  state_reg == svc_pkg::ST_EXIT_NOW);
   COV_SAVED_RESTORE: cover property (msg_code == svc_pkg::MSG_APPLIED_SAVED);
   COV_TX_CONFIRM: cover property (state_reg == svc_pkg::ST_CONF_TX && rx_valid);

endmodule

// file: design/svc_consts.svh
`ifndef SVC_CONSTS_SVH
`define SVC_CONSTS_SVH

// Clock and hold time
`define CLK_FREQ_KHZ   50000
`define HOLD_TIME_MS   3000

// Save counter limit: warning once the count is above this
`define SAVE_LIMIT     16'h03E8
`define SAVE_CNT_W     16

// Characters of the command line
`define CH_CR          8'h0D
`define CH_LF          8'h0A
`define CH_SP          8'h20
`define CH_COMMA       8'h2C
`define CH_X_LC        8'h78
`define CH_Z_LC        8'h7A
`define CH_S_LC        8'h73
`define CH_N_LC        8'h6E
`define CH_I_LC        8'h69
`define CH_N_UC        8'h4E
`define CH_I_UC        8'h49
`define CH_Y_UC        8'h59

`endif

// file: design/svc_pkg.sv
package svc_pkg;

   typedef enum logic [4:0] {
      MSG_NONE,
      MSG_PROMPT,
      MSG_E001_UNKNOWN_CMD,
      MSG_E002_PARAM_COUNT,
      MSG_E003_INVALID_PARAM,
      MSG_E004_MAX_SAVES,
      MSG_E005_SAVE_FAILED,
      MSG_CONFIRM_EXIT,
      MSG_RETURN_NORMAL,
      MSG_RETURN_INIT,
      MSG_RESTORE_CONFIRM,
      MSG_TX_CONFIRM,
      MSG_TX_NEW_PARAMS,
      MSG_APPLYING,
      MSG_APPLIED_USE_SAVE,
      MSG_APPLIED_SAVED,
      MSG_SAVE_COUNT,
      MSG_ABORTED
   } msg_t;

   typedef enum {
      ST_OUT,
      ST_IDLE,
      ST_X_SP,
      ST_X_ARG,
      ST_X_CR,
      ST_Z_CMD,
      ST_Z_ARG,
      ST_Z_CR,
      ST_SKIP,
      ST_ERR,
      ST_PROMPT,
      ST_CONF_X,
      ST_HOLD,
      ST_EXIT_NOW,
      ST_CONF_Z,
      ST_CONF_TX,
      ST_TX_SHOW,
      ST_APPLY,
      ST_SAVE_REQ,
      ST_FLASH_WAIT,
      ST_SHOW_COUNT,
      ST_WARN
   } state_t;

endpackage

// file: dv/host_term_model.sv
`timescale 1ns/1ns
// Host terminal and flash stand-in
module host_term_model #(
   parameter int FLASH_LAT = 6    // Write latency in cycles
) (
   input  wire logic       clk,         // System clock
   output logic            rx_valid,    // Character strobe
   output logic [7:0]      rx_data,     // Character
   input  wire logic       flash_save,  // Write request
   input  wire logic       write_good,  // Outcome of next write
   output logic            flash_done,  // Write finished
   output logic            flash_ok     // Outcome, valid with done
);
   int unsigned            wait_cnt = 0;
   initial begin
      rx_valid   = 1'b0;
      rx_data    = 8'h00;
      flash_done = 1'b0;
      flash_ok   = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One character per call, then idle
   task automatic send(input byte c);
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_data  = c;
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      rx_data  = ~c;
      repeat (2) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Outcome toggles outside done; stale values fail
   always @(posedge clk) begin
      if (flash_save === 1'b1) begin
         wait_cnt <= FLASH_LAT;
      end else if (wait_cnt != 0) begin
         wait_cnt <= wait_cnt - 1;
      end
      flash_done <= (wait_cnt == 1);
      flash_ok   <= (wait_cnt == 1) ? write_good : ~flash_ok;
   end
endmodule

// file: dv/service_exit_factory_restore_tb_top.sv
`timescale 1ns/1ns
module service_exit_factory_restore_tb_top;
   localparam int  HOLD = 20;
   logic           clk = 1'b0, rstn = 1'b0, enter_service = 1'b0, cfg_dirty = 1'b0;
   logic           tx_change = 1'b0, write_good = 1'b1;
   logic           rx_valid, flash_done, flash_ok, msg_valid, in_service;
   logic           goto_normal, goto_init, reload_flash, load_factory, flash_save;
   logic [7:0]     rx_data;
   logic [15:0]    save_count;
   svc_pkg::msg_t  msg_code;
   svc_pkg::msg_t  q[$];
   int             bad_count = 0, n_compared = 0, cyc = 0, t_msg = 0, t_go = 0;
   int             n_norm = 0, n_init = 0, n_reload = 0, n_fact = 0, n_save = 0;

   service_exit_factory_restore #(.HOLD_CYCLES(HOLD)) i_dut (.clk, .rstn, .rx_valid,
      .rx_data, .enter_service, .cfg_dirty, .tx_change, .flash_done, .flash_ok, .msg_valid,
      .msg_code, .in_service, .goto_normal, .goto_init, .reload_flash, .load_factory,
      .flash_save, .save_count);
   host_term_model i_host (.clk, .rx_valid, .rx_data, .flash_save, .write_good,
      .flash_done, .flash_ok);

   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (msg_valid === 1'b1) begin
         q.push_back(msg_code);
         t_msg <= cyc;
      end
      if (goto_normal === 1'b1 || goto_init === 1'b1) t_go <= cyc;
      n_norm   <= n_norm + (goto_normal === 1'b1);
      n_init   <= n_init + (goto_init === 1'b1);
      n_reload <= n_reload + (reload_flash === 1'b1);
      n_fact   <= n_fact + (load_factory === 1'b1);
      n_save   <= n_save + (flash_save === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (bad_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [127:0] got, input logic [127:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t value %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic chk_msg(input svc_pkg::msg_t got, input svc_pkg::msg_t exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t message %s expected %s", $time, got.name(), exp.name());
      end
   endtask
   task automatic line(input string s);
      foreach (s[i]) i_host.send(s[i]);
      i_host.send(8'h0D);
   endtask
   // Extra cycles catch surplus messages
   task automatic exp_seq(input svc_pkg::msg_t e[$]);
      int k = 0;
      while (q.size() < e.size() && k < 300) begin
         @(posedge clk);
         k++;
      end
      if (k == 300) begin
         bad_count++;
         $display("[ERR] %0t no message", $time);
         finish_test();
      end
      repeat (4) @(posedge clk);
      chk_val(q.size(), e.size());
      foreach (e[i]) if (i < q.size()) chk_msg(q[i], e[i]);
      q.delete();
   endtask
   task automatic enter();
      @(posedge clk);
      #1;
      enter_service = 1'b1;
      @(posedge clk);
      #1;
      enter_service = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk_val(in_service, 1);
      q.delete();
      {n_norm, n_init, n_reload} = '0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_exit_now(input string cmd, input bit init);
      enter();
      cfg_dirty = 1'b1;
      line(cmd);
      exp_seq({init ? svc_pkg::MSG_RETURN_INIT : svc_pkg::MSG_RETURN_NORMAL});
      repeat (HOLD + 10) @(posedge clk);
      chk_val({n_norm, n_init, n_reload, t_go - t_msg < 3, in_service},
         {32'(!init), 32'(init), 32'(init), 2'b10});
   endtask
   task automatic t_exit_held(input string cmd, input svc_pkg::msg_t ret, input bit dirty);
      enter();
      cfg_dirty = dirty;
      line(cmd);
      if (dirty) begin
         exp_seq({svc_pkg::MSG_CONFIRM_EXIT});
         i_host.send("Y");
      end
      exp_seq({ret});
      repeat (HOLD + 10) @(posedge clk);
      chk_val({n_norm + n_init, n_reload}, {32'd1, 31'd0, ret == svc_pkg::MSG_RETURN_INIT});
      chk_val({t_go - t_msg > HOLD, t_go - t_msg < HOLD + 5}, 2'b11);
   endtask
   task automatic t_decline();
      enter();
      cfg_dirty = 1'b1;
      line("x i");
      exp_seq({svc_pkg::MSG_CONFIRM_EXIT});
      i_host.send("N");
      exp_seq({svc_pkg::MSG_PROMPT});
      line("x n");
      exp_seq({svc_pkg::MSG_CONFIRM_EXIT});
      i_host.send("n");
      exp_seq({svc_pkg::MSG_E003_INVALID_PARAM, svc_pkg::MSG_PROMPT});
      chk_val({n_norm, n_init, in_service}, {32'd0, 32'd0, 1'b1});
   endtask
   task automatic t_errors();
      string cmds[6] = '{"q", "x,", "x", "x q", "za", "z q"};
      svc_pkg::msg_t errs[6] = '{svc_pkg::MSG_E001_UNKNOWN_CMD, svc_pkg::MSG_E002_PARAM_COUNT,
         svc_pkg::MSG_E002_PARAM_COUNT, svc_pkg::MSG_E003_INVALID_PARAM,
         svc_pkg::MSG_E002_PARAM_COUNT, svc_pkg::MSG_E003_INVALID_PARAM};
      foreach (cmds[i]) begin
         line(cmds[i]);
         exp_seq({errs[i], svc_pkg::MSG_PROMPT});
      end
   endtask
   task automatic t_restore_plain();
      tx_change = 1'b0;
      line("z");
      exp_seq({svc_pkg::MSG_RESTORE_CONFIRM});
      i_host.send("N");
      exp_seq({svc_pkg::MSG_ABORTED, svc_pkg::MSG_PROMPT});
      chk_val(n_fact, 0);
      line("z");
      exp_seq({svc_pkg::MSG_RESTORE_CONFIRM});
      i_host.send("Y");
      exp_seq({svc_pkg::MSG_APPLYING, svc_pkg::MSG_APPLIED_USE_SAVE, svc_pkg::MSG_PROMPT});
      chk_val({n_fact, n_save}, {32'd1, 32'd0});
   endtask
   task automatic zsave(input svc_pkg::msg_t tail[$]);
      line("z s");
      exp_seq({svc_pkg::MSG_RESTORE_CONFIRM});
      i_host.send("Y");
      if (tx_change) begin
         exp_seq({svc_pkg::MSG_TX_CONFIRM});
         i_host.send("Y");
         exp_seq({svc_pkg::MSG_TX_NEW_PARAMS, svc_pkg::MSG_APPLYING, tail});
      end else begin
         exp_seq({svc_pkg::MSG_APPLYING, tail});
      end
   endtask
   task automatic t_saves();
      svc_pkg::msg_t ok[$] = {svc_pkg::MSG_APPLIED_SAVED, svc_pkg::MSG_SAVE_COUNT,
         svc_pkg::MSG_PROMPT};
      tx_change  = 1'b1;
      write_good = 1'b0;
      zsave({svc_pkg::MSG_E005_SAVE_FAILED, svc_pkg::MSG_PROMPT});
      chk_val(save_count, 0);
      write_good = 1'b1;
      zsave(ok);
      chk_val({n_fact, n_save, save_count}, {32'd3, 32'd2, 16'h0001});
      tx_change = 1'b0;
      // Only the save past the wear limit warns
      for (int i = 2; i <= 1000; i++) zsave(ok);
      ok.insert(2, svc_pkg::MSG_E004_MAX_SAVES);
      zsave(ok);
      chk_val({n_save, save_count}, {32'd1002, 16'h03E9});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_exit_now("x N", 1'b0);
      t_exit_now("x I", 1'b1);
      t_exit_held("x n", svc_pkg::MSG_RETURN_NORMAL, 1'b0);
      t_exit_held("x n", svc_pkg::MSG_RETURN_NORMAL, 1'b1);
      t_exit_held("x i", svc_pkg::MSG_RETURN_INIT, 1'b1);
      t_decline();
      t_errors();
      t_restore_plain();
      t_saves();
      finish_test();
   end
endmodule
